// ---- ims_pkg.sv ----
// Package for the interrupt enable mask set/read block
package ims_pkg;
	localparam int         IMS_DW           = 32;
	localparam int         IMS_AW           = 8;
	localparam logic [7:0] IMS_OFF_SET      = 8'hd0;
	localparam logic [7:0] IMS_OFF_CLEAR    = 8'hd8;
	localparam logic [7:0] IMS_OFF_CAUSE    = 8'hc0;
	localparam logic [7:0] IMS_OFF_ISTAT    = 8'he8;
	localparam logic [7:0] IMS_OFF_IMASK    = 8'hec;
	localparam logic [31:0] IMS_RESET_VAL   = 32'h0000_0000;
	// Mask bit positions
	localparam int IMS_B_TX_WB      = 0;
	localparam int IMS_B_TX_QE      = 1;
	localparam int IMS_B_LINK       = 2;
	localparam int IMS_B_RX_SEQ     = 3;
	localparam int IMS_B_RX_DMT     = 4;
	localparam int IMS_B_RX_OVR     = 6;
	localparam int IMS_B_RX_TMR     = 7;
	localparam int IMS_B_MGMT       = 9;
	localparam int IMS_B_RX_CFG     = 10;
	localparam int IMS_B_GPI_LO     = 13;
	localparam int IMS_B_GPI_HI     = 14;
	localparam int IMS_B_TX_LOW     = 15;
	localparam int IMS_B_SMALL_PACKET_DETECT_MASK       = 16;
	localparam int IMS_B_ACK        = 17;
	localparam int IMS_B_PAR_LO     = 20;
	localparam int IMS_B_PAR_HI     = 25;
	// Writable positions on every variant
	localparam logic [31:0] IMS_BASE_BITS   = 32'h0003_82d7;
	// Positions dropped on reduced variants
	localparam logic [31:0] IMS_REDUCE_BITS = 32'h0000_6408;
	// Parity error masks on parity variants
	localparam logic [31:0] IMS_PAR_BITS    = 32'h03f0_0000;
	localparam logic [31:0] IMS_ZERO        = 32'h0000_0000;
	// Block events: mask set write and mask clear write
	localparam int IMS_NEV = 2;
	localparam logic [1:0] IMS_EV_ZERO = 2'h0;

	typedef struct packed {
		logic [IMS_AW-1:0] addr;
		logic [IMS_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} ims_req_s;

	typedef struct packed {
		logic [31:0]        mask;
		logic [IMS_DW-1:0]  rdata;
		logic [IMS_NEV-1:0] istat;
		logic [IMS_NEV-1:0] imask;
	} ims_state_s;
endpackage

// ---- ims_mask.sv ----
// Interrupt enable mask set/read logic with clear path and host interrupt request
// Summary of operation
// - A mask bit of one enables its interrupt source and a zero disables it.
// - The host interrupt is raised while any mask bit meets its set cause bit.
// - Writing one to a mask set register bit sets that mask bit.
// - Writing zero to a mask set register bit leaves that mask bit unchanged.
// - Reading the mask set register returns the current mask.
// - Transmit masks sit at bits 0, 1 and 15 and reset to zero.
// - Link change mask is bit 2 and management access done mask is bit 9, both reset to zero.
// - Receive masks sit at bits 3, 4, 6 and 7 and reset to zero.
// - Config set mask is bit 10, general inputs bits 14:13, small packet 16, acknowledge 17.
// - Parity variants have parity masks at bits 25:20; all higher bits are reserved.
// - A parameter turns the sequence, config set and general input masks into reserved bits.
// - Writing one to a mask clear register bit clears that mask bit; zeros leave it.
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
module ims_mask
	import ims_pkg::*;
#(
	parameter bit PARITY_EN  = 1'b1,
	parameter bit REDUCED    = 1'b0
) (
	input  wire logic              ref_clk,
	input  wire logic              srst,
	input  wire logic [IMS_AW-1:0] reg_addr,
	input  wire logic [IMS_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [IMS_DW-1:0] reg_rdata,
	input  wire logic [31:0]       cause_bits,
	input  wire logic              clear_strobe,
	input  wire logic [31:0]       clear_bits,
	output logic      [31:0]       mask_out,
	output logic                   host_irq,
	output logic                   blk_irq
);

	// Reduced variants drop the sequence, config set and general input positions
	localparam logic [31:0] IMPL_BITS = (REDUCED ? IMS_BASE_BITS : (IMS_BASE_BITS | IMS_REDUCE_BITS))
		| (PARITY_EN ? IMS_PAR_BITS : IMS_ZERO);

	ims_req_s   req;
	ims_state_s st_q;
	ims_state_s st_d;
	logic       set_wr;
	logic       clr_wr;
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic [IMS_NEV-1:0] ev;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	assign set_wr  = req.wr && (req.addr == IMS_OFF_SET);
	assign clr_wr  = req.wr && (req.addr == IMS_OFF_CLEAR);
	assign set_vec = set_wr ? (req.wdata & IMPL_BITS) : IMS_ZERO;
	assign clr_vec = (clr_wr ? (req.wdata & IMPL_BITS) : IMS_ZERO)
		| (clear_strobe ? (clear_bits & IMPL_BITS) : IMS_ZERO);
	assign ev      = {clr_wr, set_wr};

	always_comb begin
		st_d = st_q;
		// Set wins over clear on the same bit
		st_d.mask = ((st_q.mask & ~clr_vec) | set_vec) & IMPL_BITS;
		st_d.rdata = '0;
		if (req.rd) begin
			unique case (req.addr)
				IMS_OFF_SET:   st_d.rdata = st_q.mask;
				IMS_OFF_CAUSE: st_d.rdata = cause_bits & IMPL_BITS;
				IMS_OFF_ISTAT: st_d.rdata = {{(IMS_DW-IMS_NEV){1'b0}}, st_q.istat};
				IMS_OFF_IMASK: st_d.rdata = {{(IMS_DW-IMS_NEV){1'b0}}, st_q.imask};
				default:       st_d.rdata = '0;
			endcase
		end
		if (req.rd && req.addr == IMS_OFF_ISTAT)
			st_d.istat = ev;
		else
			st_d.istat = st_q.istat | ev;
		if (set_wr == 1'b0 && req.wr && req.addr == IMS_OFF_IMASK)
			st_d.imask = req.wdata[IMS_NEV-1:0];
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= '{mask: IMS_RESET_VAL, rdata: '0, istat: IMS_EV_ZERO, imask: IMS_EV_ZERO};
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign mask_out  = st_q.mask;
	assign host_irq  = |(st_q.mask & cause_bits);
	assign blk_irq   = |(st_q.istat & st_q.imask);

	// Assertions
	set_takes_a: assert property (@(posedge ref_clk) disable iff (srst)
		set_wr && !srst ##0 (1'b1) |=> ((mask_out & $past(set_vec)) == $past(set_vec)))
		else $error("mask set write did not set bits");
	zero_keeps_a: assert property (@(posedge ref_clk) disable iff (srst)
		(!clr_wr && !clear_strobe) |=> ((mask_out & ~$past(set_vec)) == ($past(mask_out) & ~$past(set_vec))))
		else $error("zero write changed mask");
	clear_takes_a: assert property (@(posedge ref_clk) disable iff (srst)
		(clr_wr && !set_wr) |=> ((mask_out & $past(clr_vec)) == IMS_ZERO))
		else $error("mask clear write did not clear bits");
	read_returns_a: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && reg_addr == IMS_OFF_SET) |=> (reg_rdata == $past(mask_out)))
		else $error("mask read data wrong");
	irq_follows_a: assert property (@(posedge ref_clk) disable iff (srst)
		host_irq == ((mask_out & cause_bits) != IMS_ZERO))
		else $error("host interrupt mismatch");
	reserved_zero_a: assert property (@(posedge ref_clk) disable iff (srst)
		(mask_out & ~IMPL_BITS) == IMS_ZERO)
		else $error("reserved mask bit set");
	reduced_bits_a: assert property (@(posedge ref_clk) disable iff (srst)
		REDUCED |-> ((mask_out & IMS_REDUCE_BITS) == IMS_ZERO))
		else $error("reduced variant bit set");
	reset_zero_a: assert property (@(posedge ref_clk)
		srst |=> (mask_out == IMS_RESET_VAL))
		else $error("mask not zero after reset");
	set_priority_a: assert property (@(posedge ref_clk) disable iff (srst)
		(clear_strobe && set_wr) |=> ((mask_out & $past(set_vec)) == $past(set_vec)))
		else $error("clear overrode set");
	link_pos_a: assert property (@(posedge ref_clk) disable iff (srst)
		(set_wr && reg_wdata[IMS_B_LINK] && !srst) |=> mask_out[IMS_B_LINK])
		else $error("link mask bit not set");

	set_cov_c: cover property (@(posedge ref_clk) set_wr ##1 host_irq);
	clr_cov_c: cover property (@(posedge ref_clk) clr_wr ##1 !host_irq);
	both_cov_c: cover property (@(posedge ref_clk) set_wr && clear_strobe);
	blk_cov_c: cover property (@(posedge ref_clk) blk_irq);

endmodule // ims_mask

// ---- ims_mask_tb_top.sv ----
// Self-checking testbench for the interrupt enable mask block
`timescale 1ns/100ps
module ims_mask_tb_top;
	import ims_pkg::*;
	localparam logic [31:0] IMP = IMS_BASE_BITS | IMS_REDUCE_BITS | IMS_PAR_BITS;
	logic        ref_clk, srst, reg_wr, reg_rd, clear_strobe, host_irq, blk_irq;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, cause_bits, clear_bits, mask_out, em, rv, d;
	logic [1:0]  ev;
	int          bad_count, n_tests;
	ims_mask ims_mask_inst (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cause_bits(cause_bits),
		.clear_strobe(clear_strobe), .clear_bits(clear_bits), .mask_out(mask_out),
		.host_irq(host_irq), .blk_irq(blk_irq));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// One bus cycle, optionally with a clear strobe in the same cycle; set wins over clear
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] x, input logic cs, input logic [31:0] cb);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= w;
		reg_rd <= !w && !cs;
		clear_strobe <= cs;
		clear_bits <= cb;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		clear_strobe <= 1'b0;
		#1 rv = reg_rdata;
		if (cs) em &= ~cb;
		if (w && a == IMS_OFF_SET) begin
			em |= x & IMP;
			ev[0] = 1'b1;
		end
		if (w && a == IMS_OFF_CLEAR) begin
			em &= ~x;
			ev[1] = 1'b1;
		end
		chk("mask_out", mask_out, em);
		chk("host_irq", {31'h0, host_irq}, {31'h0, |(em & cause_bits)});
	endtask
	initial begin
		srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
		cause_bits = 32'hffff_ffff; clear_strobe = 1'b0; clear_bits = 32'h0;
		em = 32'h0; ev = 2'h0; bad_count = 0; n_tests = 0;
		void'($urandom(81));
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		acc(0, IMS_OFF_SET, 32'h0, 0, 32'h0);
		chk("reset read", rv, 32'h0);
		for (int b = 0; b < 32; b++) begin
			cause_bits <= 32'h1 << b;
			acc(1, IMS_OFF_SET, 32'h1 << b, 0, 32'h0);
			acc(0, IMS_OFF_SET, 32'h0, 0, 32'h0);
			chk("bit map", rv, (32'h1 << b) & IMP);
			acc(1, IMS_OFF_SET, 32'h0, 0, 32'h0);
			acc(1, IMS_OFF_CLEAR, 32'h1 << b, 0, 32'h0);
		end
		$display("test bit map done");
		for (int i = 0; i < 60; i++) begin
			cause_bits <= $urandom;
			d = $urandom & IMP;
			case ($urandom % 4)
				0: acc(1, IMS_OFF_SET, d, 0, 32'h0);
				1: acc(1, IMS_OFF_CLEAR, d, 0, 32'h0);
				2: acc(0, IMS_OFF_SET, 32'h0, 1, d);
				default: acc(1, IMS_OFF_SET, d, 1, d | $urandom);
			endcase
			acc(0, IMS_OFF_SET, 32'h0, 0, 32'h0);
			chk("mask read", rv, em);
		end
		$display("test random done");
		acc(0, IMS_OFF_CLEAR, 32'h0, 0, 32'h0);
		chk("clear read", rv, 32'h0);
		acc(0, 8'h04, 32'h0, 0, 32'h0);
		chk("unmapped", rv, 32'h0);
		acc(0, IMS_OFF_CAUSE, 32'h0, 0, 32'h0);
		chk("cause", rv, cause_bits & IMP);
		acc(1, IMS_OFF_IMASK, 32'h3, 0, 32'h0);
		acc(0, IMS_OFF_IMASK, 32'h0, 0, 32'h0);
		chk("event mask", rv, 32'h3);
		chk("blk_irq", {31'h0, blk_irq}, {31'h0, |ev});
		acc(0, IMS_OFF_ISTAT, 32'h0, 0, 32'h0);
		chk("event stat", rv, {30'h0, ev});
		acc(0, IMS_OFF_ISTAT, 32'h0, 0, 32'h0);
		chk("stat cleared", rv | blk_irq, 32'h0);
		$display("test events done");
		conclude();
	end
endmodule // ims_mask_tb_top
